//--- hw/rail_cfg_map.svh
// Purpose: offsets, field positions, masks and times of the rail config bank
// Assumes: included by rail_config_register_bank, host_model and testbench
// Notes: most values here are used by name; the bank decodes register codes as offsets from CMD_BASE
//
// Summary of operation
// R1 - spread bit seven enables frequency spreading
// R2 - spread bit four picks five or ten percent
// R3 - spread bit zero picks 4.5kHz or 9kHz
// R4 - comm failure drops power ok unless flag-only
// R5 - crc failure drops power ok unless flag-only
// R6 - protection bit zero allows optional check byte
// R7 - power ok release delay: 0,2,5,10ms
// R8 - power ok bit zero picks window width
// R9 - two-bit gate drive strength, low to high
// R10 - light-load bit one enables output discharge
// R11 - light-load bit zero picks ccm or dcm
// R12 - turn-on delay is count times unit
// R13 - turn-off delay is count times unit
// R14 - delay unit 0.25ms or 2.5ms
// R15 - frequency bit one picks 2.2 or 3.3MHz
// R16 - frequency bit zero picks 100 or 125%
// R17 - input start field selects start level
// R18 - input stop field selects stop level
// R19 - host never mixes lockout with other levels
// R20 - address register low nibble gives address bits
// R21 - config access only on all-rails page
// R22 - page all ones, 0..3 valid, others ignored
// R23 - target-only bus endpoint, up to 1Mbps
// R24 - reserved bits read zero, fields hold
`ifndef RAIL_CFG_MAP_SVH
`define RAIL_CFG_MAP_SVH

// command codes
`define CMD_PAGE 8'h00
`define CMD_CLEAR 8'h03
`define CMD_BASE 8'hC4
`define CMD_SPREAD 8'hC4
`define CMD_FAULT_MAP 8'hC5
`define CMD_PKT_CHECK 8'hCB
`define CMD_PG_CFG 8'hCC
`define CMD_DRIVE 8'hCD
`define CMD_LIGHT 8'hCE
`define CMD_SEQ 8'hCF
`define CMD_UNIT 8'hD0
`define CMD_FREQ 8'hD1
`define CMD_VIN 8'hD2
`define CMD_ADDR 8'hD3

// page values
`define PAGE_ALL 8'hFF
`define PAGE_LAST_RAIL 8'h03
`define PAGE_RESET 8'hFF

// writable-bit masks per register index (code minus base)
`define MASK_SPREAD 8'h91
`define MASK_FAULT_MAP 8'h0C
`define MASK_PKT_CHECK 8'h01
`define MASK_PG_CFG 8'h0F
`define MASK_DRIVE 8'h03
`define MASK_LIGHT 8'h03
`define MASK_SEQ 8'hFF
`define MASK_UNIT 8'h01
`define MASK_FREQ 8'h03
`define MASK_VIN 8'h0F
`define MASK_ADDR 8'h0F
`define MASK_NONE 8'h00
`define REG_RESET 8'h00

// field positions
`define SS_EN_BIT 7
`define SS_RANGE_BIT 4
`define SS_RATE_BIT 0
`define FM_COMM_BIT 3
`define FM_CRC_BIT 2
`define PC_ALLOW_BIT 0
`define PG_LEVEL_BIT 3
`define PG_DLY_HI 2
`define PG_DLY_LO 1
`define PG_WIN_BIT 0
`define LL_DIS_BIT 1
`define LL_MODE_BIT 0
`define UNIT_BIT 0
`define FR_FREQ_BIT 1
`define FR_CURRENT_LIMIT_SEL_BIT 0
`define VIN_LOCKOUT 2'b00

// times and clock
`define CLK_MHZ 20
`define UNIT_SHORT_US 250
`define UNIT_LONG_US 2500
`define PG_DLY_A_US 2000
`define PG_DLY_B_US 5000
`define PG_DLY_C_US 10000

`endif

//--- hw/rail_cfg_pkg.sv
// Purpose: types shared by the rail config bank and its users
// Assumes: nothing
// Notes: command and config outputs travel as packed structs
package rail_cfg_pkg;
    // one command from the serial protocol engine
    typedef struct packed {
        logic wr;         // write strobe, one cycle
        logic rd;         // read strobe, one cycle
        logic [7:0] code; // command code
        logic [7:0] data; // write data byte
    } cmd_type;

    // settings driven to the analog side
    typedef struct packed {
        logic spread_enable;
        logic spread_range_sel;
        logic spread_rate_sel;
        logic packet_check_allow;
        logic power_ok_level_sel;
        logic power_ok_window_sel;
        logic [1:0] driver_strength_sel;
        logic output_discharge_en;
        logic light_mode_dcm;
        logic switch_freq_sel;
        logic current_limit_sel;
        logic [1:0] input_start_sel;
        logic [1:0] input_stop_sel;
        logic [3:0] bus_address_bits;
    } cfg_type;

    // turn-on/turn-off sequencer states
    typedef enum logic [3:0] {
        SEQ_OFF = 4'b0001,
        SEQ_ON_WAIT = 4'b0010,
        SEQ_ON = 4'b0100,
        SEQ_OFF_WAIT = 4'b1000
    } seq_state_type;
endpackage

//--- hw/rail_config_register_bank.sv
// Purpose: all-rails configuration bank with power-ok and sequencing
// Assumes: commands arrive decoded from the serial engine, synchronous
// Notes: the bank only answers; it never starts a bus transfer
`timescale 1ns/100ps
`include "rail_cfg_map.svh"

module rail_config_register_bank #(
    parameter int UNIT_SHORT_CYC = `UNIT_SHORT_US * `CLK_MHZ,
    parameter int UNIT_LONG_CYC = `UNIT_LONG_US * `CLK_MHZ,
    parameter int PG_DLY_A_CYC = `PG_DLY_A_US * `CLK_MHZ,
    parameter int PG_DLY_B_CYC = `PG_DLY_B_US * `CLK_MHZ,
    parameter int PG_DLY_C_CYC = `PG_DLY_C_US * `CLK_MHZ
) (
    input wire logic clk,
    input wire logic rst,
    input rail_cfg_pkg::cmd_type cmd,
    input wire logic comm_fail,
    input wire logic crc_fail,
    input wire logic power_ok_raw,
    input wire logic rail_on_req,
    output logic [7:0] rd_data,
    output logic rd_valid,
    output logic cmd_refused,
    output logic comm_fail_seen,
    output logic crc_fail_seen,
    output logic power_ok_out,
    output logic rail_en,
    output rail_cfg_pkg::cfg_type cfg
);
    import rail_cfg_pkg::*;

    localparam int NREG = 16; // indices base..base+15
    localparam int CW = 20;   // counter width, holds the longest count

    // parameter sanity
    generate
        if (UNIT_SHORT_CYC < 1 || UNIT_LONG_CYC < 1 ||
            UNIT_LONG_CYC >= (1 << CW) || PG_DLY_A_CYC < 1 ||
            PG_DLY_B_CYC < 1 || PG_DLY_C_CYC >= (1 << CW)) begin : g_bad
            $error("rail bank: cycle count parameter out of range");
        end
    endgenerate

    // writable mask per index, zero for unmapped codes
    localparam logic [7:0] MASKS [NREG] = '{
        `MASK_SPREAD, `MASK_FAULT_MAP, `MASK_NONE, `MASK_NONE,
        `MASK_NONE, `MASK_NONE, `MASK_NONE, `MASK_PKT_CHECK,
        `MASK_PG_CFG, `MASK_DRIVE, `MASK_LIGHT, `MASK_SEQ,
        `MASK_UNIT, `MASK_FREQ, `MASK_VIN, `MASK_ADDR};

    logic [7:0] regs_q [NREG]; // config storage
    logic [7:0] page_q;        // page selection
    logic [7:0] offs;          // code minus base
    logic [3:0] idx;           // register index
    logic in_bank;             // code maps to a config register
    logic page_all;            // all-rails page selected
    logic vin_mixed;           // start/stop write mixes lockout
    logic wr_ok;               // config write accepted
    logic page_wr_ok;          // page write accepted
    logic refuse;              // access not honoured

    // decode
    always_comb begin
        offs = cmd.code - `CMD_BASE;
        idx = offs[3:0];
        in_bank = (cmd.code >= `CMD_BASE) && (offs < 8'(NREG)) &&
                  (MASKS[idx] != `MASK_NONE);
        page_all = (page_q == `PAGE_ALL);
        // lockout must be on both fields or on neither [R19]
        vin_mixed = (cmd.code == `CMD_VIN) &&
            ((cmd.data[3:2] == `VIN_LOCKOUT) !=
             (cmd.data[1:0] == `VIN_LOCKOUT));
    end

    // acceptance
    always_comb begin
        wr_ok = cmd.wr && in_bank && page_all && !vin_mixed; // [R21]
        page_wr_ok = cmd.wr && (cmd.code == `CMD_PAGE) &&
            ((cmd.data <= `PAGE_LAST_RAIL) || (cmd.data == `PAGE_ALL));
        refuse = (cmd.wr || cmd.rd) && (cmd.code != `CMD_PAGE) &&
                 (cmd.code != `CMD_CLEAR) && !(in_bank && page_all) ||
                 (cmd.wr && vin_mixed) ||
                 (cmd.wr && (cmd.code == `CMD_PAGE) && !page_wr_ok);
    end

    // page register, bad values leave it unchanged
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            page_q <= `PAGE_RESET;
        end else if (page_wr_ok) begin
            page_q <= cmd.data; // [R22]
        end
    end

    // one byte register per index; reserved bits never store
    genvar gi;
    generate
        for (gi = 0; gi < NREG; gi++) begin : g_reg
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    regs_q[gi] <= `REG_RESET;
                end else if (wr_ok && idx == 4'(gi)) begin
                    regs_q[gi] <= cmd.data & MASKS[gi]; // [R24]
                end
            end
        end
    endgenerate

    // read answer one cycle after the strobe; the bank only responds
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_data <= `REG_RESET;
            rd_valid <= 1'b0;
            cmd_refused <= 1'b0;
        end else begin
            rd_valid <= cmd.rd; // [R23]
            cmd_refused <= refuse;
            if (cmd.rd) begin
                if (cmd.code == `CMD_PAGE) begin
                    rd_data <= page_q;
                end else if (in_bank && page_all) begin
                    rd_data <= regs_q[idx] & MASKS[idx]; // [R24]
                end else begin
                    rd_data <= `REG_RESET;
                end
            end
        end
    end

    // config outputs straight from storage
    always_comb begin
        cfg.spread_enable = regs_q[0][`SS_EN_BIT];        // [R1]
        cfg.spread_range_sel = regs_q[0][`SS_RANGE_BIT];  // [R2]
        cfg.spread_rate_sel = regs_q[0][`SS_RATE_BIT];    // [R3]
        cfg.packet_check_allow = regs_q[7][`PC_ALLOW_BIT]; // [R6]
        cfg.power_ok_level_sel = regs_q[8][`PG_LEVEL_BIT];
        cfg.power_ok_window_sel = regs_q[8][`PG_WIN_BIT]; // [R8]
        cfg.driver_strength_sel = regs_q[9][1:0];         // [R9]
        cfg.output_discharge_en = regs_q[10][`LL_DIS_BIT]; // [R10]
        cfg.light_mode_dcm = regs_q[10][`LL_MODE_BIT];    // [R11]
        cfg.switch_freq_sel = regs_q[13][`FR_FREQ_BIT];   // [R15]
        cfg.current_limit_sel = regs_q[13][`FR_CURRENT_LIMIT_SEL_BIT]; // [R16]
        cfg.input_start_sel = regs_q[14][3:2];            // [R17]
        cfg.input_stop_sel = regs_q[14][1:0];             // [R18]
        cfg.bus_address_bits = regs_q[15][3:0];           // [R20]
    end

    // sticky fault flags; a new fault beats a clear in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            comm_fail_seen <= 1'b0;
            crc_fail_seen <= 1'b0;
        end else begin
            comm_fail_seen <= comm_fail ||
                (comm_fail_seen && !(cmd.wr && cmd.code == `CMD_CLEAR));
            crc_fail_seen <= crc_fail ||
                (crc_fail_seen && !(cmd.wr && cmd.code == `CMD_CLEAR));
        end
    end

    logic comm_holds_low; // mapped comm fault forces power ok low
    logic crc_holds_low;  // mapped crc fault forces power ok low
    logic [CW-1:0] pg_target; // release delay in cycles
    logic [CW-1:0] pg_cnt_q;  // release delay counter
    logic pg_rel_q;           // raw power ok released

    // fault mapping onto power ok
    always_comb begin
        comm_holds_low = comm_fail_seen && !regs_q[1][`FM_COMM_BIT]; // [R4]
        crc_holds_low = crc_fail_seen && !regs_q[1][`FM_CRC_BIT];    // [R5]
        case (regs_q[8][`PG_DLY_HI:`PG_DLY_LO]) // [R7]
            2'b00: pg_target = '0;
            2'b01: pg_target = CW'(PG_DLY_A_CYC);
            2'b10: pg_target = CW'(PG_DLY_B_CYC);
            default: pg_target = CW'(PG_DLY_C_CYC);
        endcase
    end

    // release delay; loss of power ok drops at once
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pg_cnt_q <= '0;
            pg_rel_q <= 1'b0;
        end else if (!power_ok_raw) begin
            pg_cnt_q <= '0;
            pg_rel_q <= 1'b0;
        end else if (!pg_rel_q) begin
            if (pg_cnt_q >= pg_target) begin
                pg_rel_q <= 1'b1; // [R7]
            end else begin
                pg_cnt_q <= pg_cnt_q + 1'b1;
            end
        end
    end

    assign power_ok_out = pg_rel_q && power_ok_raw &&
                          !comm_holds_low && !crc_holds_low; // [R4] [R5]

    seq_state_type seq_q;   // sequencer state
    logic [CW-1:0] pre_q;   // cycles within one delay unit
    logic [3:0] units_q;    // units elapsed
    logic [CW-1:0] unit_cyc; // selected unit length
    logic unit_tick;        // one unit completed

    // delay unit selection
    always_comb begin
        unit_cyc = regs_q[12][`UNIT_BIT] ? CW'(UNIT_LONG_CYC)
                                         : CW'(UNIT_SHORT_CYC); // [R14]
        unit_tick = (pre_q == unit_cyc - 1'b1);
    end

    // turn-on/turn-off sequencer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            seq_q <= SEQ_OFF;
            pre_q <= '0;
            units_q <= '0;
        end else begin
            case (seq_q)
                SEQ_OFF: begin
                    pre_q <= '0;
                    units_q <= '0;
                    if (rail_on_req) begin
                        seq_q <= SEQ_ON_WAIT;
                    end
                end
                SEQ_ON_WAIT: begin
                    if (!rail_on_req) begin
                        seq_q <= SEQ_OFF;
                    end else if (units_q == regs_q[11][7:4]) begin
                        seq_q <= SEQ_ON; // [R12]
                    end else if (unit_tick) begin
                        pre_q <= '0;
                        units_q <= units_q + 1'b1;
                    end else begin
                        pre_q <= pre_q + 1'b1;
                    end
                end
                SEQ_ON: begin
                    pre_q <= '0;
                    units_q <= '0;
                    if (!rail_on_req) begin
                        seq_q <= SEQ_OFF_WAIT;
                    end
                end
                SEQ_OFF_WAIT: begin
                    if (rail_on_req) begin
                        seq_q <= SEQ_ON;
                    end else if (units_q == regs_q[11][3:0]) begin
                        seq_q <= SEQ_OFF; // [R13]
                    end else if (unit_tick) begin
                        pre_q <= '0;
                        units_q <= units_q + 1'b1;
                    end else begin
                        pre_q <= pre_q + 1'b1;
                    end
                end
                default: seq_q <= SEQ_OFF;
            endcase
        end
    end

    assign rail_en = (seq_q == SEQ_ON) || (seq_q == SEQ_OFF_WAIT);

    // checks
    property p_reserved_zero;
        @(posedge clk) disable iff (rst)
        cmd.rd && in_bank && page_all |=> (rd_data & ~MASKS[$past(idx)]) == 0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) // [R24]
        else $error("reserved bits read nonzero");

    property p_page_gate;
        @(posedge clk) disable iff (rst)
        cmd.wr && cmd.code == `CMD_SPREAD && !page_all
        |=> $stable(cfg.spread_enable) && $stable(cfg.spread_rate_sel);
    endproperty
    a_page_gate: assert property (p_page_gate) // [R21]
        else $error("config written off the all-rails page");

    property p_page_ignore;
        @(posedge clk) disable iff (rst)
        cmd.wr && cmd.code == `CMD_PAGE && cmd.data > `PAGE_LAST_RAIL &&
        cmd.data != `PAGE_ALL |=> $stable(page_q) && cmd_refused;
    endproperty
    a_page_ignore: assert property (p_page_ignore) // [R22]
        else $error("invalid page value took effect");

    property p_spread_write;
        @(posedge clk) disable iff (rst)
        cmd.wr && cmd.code == `CMD_SPREAD && page_all
        |=> cfg.spread_enable == $past(cmd.data[`SS_EN_BIT]) &&
            cfg.spread_range_sel == $past(cmd.data[`SS_RANGE_BIT]);
    endproperty
    a_spread_write: assert property (p_spread_write) // [R1]
        else $error("spread settings not taken");

    property p_comm_pg;
        @(posedge clk) disable iff (rst)
        comm_fail && !regs_q[1][`FM_COMM_BIT] |=> !power_ok_out;
    endproperty
    a_comm_pg: assert property (p_comm_pg) // [R4]
        else $error("comm failure did not drop power ok");

    property p_crc_pg;
        @(posedge clk) disable iff (rst)
        crc_fail |=> crc_fail_seen && (regs_q[1][`FM_CRC_BIT] || !power_ok_out);
    endproperty
    a_crc_pg: assert property (p_crc_pg) // [R5]
        else $error("crc failure mapping wrong");

    property p_pg_drop;
        @(posedge clk) disable iff (rst)
        !power_ok_raw |=> !pg_rel_q;
    endproperty
    a_pg_drop: assert property (p_pg_drop) // [R7]
        else $error("power ok not dropped at once");

    property p_pg_wait;
        @(posedge clk) disable iff (rst)
        $rose(power_ok_raw) && regs_q[8][`PG_DLY_HI:`PG_DLY_LO] != 2'b00
        |=> !pg_rel_q [*8];
    endproperty
    a_pg_wait: assert property (p_pg_wait) // [R7]
        else $error("power ok released before its delay");

    property p_seq_on_now;
        @(posedge clk) disable iff (rst)
        seq_q == SEQ_OFF && rail_on_req && regs_q[11][7:4] == 4'h0
        |=> ##1 rail_en;
    endproperty
    a_seq_on_now: assert property (p_seq_on_now) // [R12]
        else $error("zero turn-on delay not honoured");

    c_page_select: cover property (@(posedge clk) disable iff (rst)
        page_wr_ok ##1 wr_ok);
    c_rail_cycle: cover property (@(posedge clk) disable iff (rst)
        seq_q == SEQ_OFF_WAIT ##1 seq_q == SEQ_OFF);
    c_pg_release: cover property (@(posedge clk) disable iff (rst)
        $rose(power_ok_out));
endmodule

//--- tb/host_model.sv
// Purpose: host side of the command port, one byte per transfer
// Assumes: the bank takes a strobe at the rising edge after it is raised
// Notes: answers are sampled just after the taking edge
`timescale 1ns/100ps
`include "rail_cfg_map.svh"

module host_model (
    input wire logic clk,
    output rail_cfg_pkg::cmd_type cmd,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid,
    input wire logic cmd_refused
);
    import rail_cfg_pkg::*;

    // idle port until the first transfer
    initial begin
        cmd = '0;
    end

    // host always starts, bank only answers; one strobe cycle each
    task automatic xfer(input logic wr, input logic [7:0] code,
        input logic [7:0] data, output logic [7:0] q,
        output logic valid, output logic refused);
        @(posedge clk);
        cmd <= '{wr: wr, rd: !wr, code: code, data: data};
        @(posedge clk);
        cmd <= '0;
        #1;
        q = rd_data;
        valid = rd_valid;
        refused = cmd_refused;
    endtask

    // all-rails page before any config access
    task automatic select_all(output logic refused);
        logic [7:0] q;
        logic v;
        xfer(1'b1, `CMD_PAGE, `PAGE_ALL, q, v, refused);
    endtask
endmodule

//--- tb/testbench.sv
// Purpose: self-checking bench for the rail config bank
// Assumes: host_model drives the command port
// Notes: long counts shortened through the bank parameters
`timescale 1ns/100ps
`include "rail_cfg_map.svh"

module testbench;
    import rail_cfg_pkg::*;
    localparam int US = 4; // short unit, cycles
    localparam int UL = 40; // long unit, cycles
    logic clk;
    logic rst;
    logic comm_fail;
    logic crc_fail;
    logic power_ok_raw;
    logic rail_on_req;
    cmd_type cmd;
    logic [7:0] rd_data;
    logic rd_valid;
    logic cmd_refused;
    logic comm_fail_seen;
    logic crc_fail_seen;
    logic power_ok_out;
    logic rail_en;
    cfg_type cfg;
    int bad_count;
    int samples_checked;
    logic [7:0] q;
    logic v;
    logic r;
    // write data, readback, expected cfg image
    logic [7:0] t_code[17] = '{8'hC4, 8'hC4, 8'hC4, 8'hC5, 8'hCB, 8'hCC,
        8'hCC, 8'hCD, 8'hCD, 8'hCE, 8'hCE, 8'hCF, 8'hD0, 8'hD1, 8'hD1,
        8'hD2, 8'hD3};
    logic [7:0] t_data[17] = '{8'hFF, 8'h10, 8'h01, 8'hFF, 8'hFF, 8'hFF,
        8'h01, 8'h01, 8'h02, 8'h02, 8'h01, 8'hFF, 8'hFF, 8'h02, 8'h01,
        8'h09, 8'hF5};
    logic [7:0] t_back[17] = '{8'h91, 8'h10, 8'h01, 8'h0C, 8'h01, 8'h0F,
        8'h01, 8'h01, 8'h02, 8'h02, 8'h01, 8'hFF, 8'h01, 8'h02, 8'h01,
        8'h09, 8'h05};
    logic [19:0] t_cfg[17] = '{20'hE_0000, 20'h4_0000, 20'h2_0000, 20'h0,
        20'h1_0000, 20'h0_C000, 20'h0_4000, 20'h0_1000, 20'h0_2000,
        20'h0_0800, 20'h0_0400, 20'h0, 20'h0, 20'h0_0200, 20'h0_0100,
        20'h0_0090, 20'h0_0005};

    rail_config_register_bank #(.UNIT_SHORT_CYC(US), .UNIT_LONG_CYC(UL),
        .PG_DLY_A_CYC(8), .PG_DLY_B_CYC(16), .PG_DLY_C_CYC(24)) uut (
        .clk(clk), .rst(rst), .cmd(cmd), .comm_fail(comm_fail),
        .crc_fail(crc_fail), .power_ok_raw(power_ok_raw),
        .rail_on_req(rail_on_req), .rd_data(rd_data), .rd_valid(rd_valid),
        .cmd_refused(cmd_refused), .comm_fail_seen(comm_fail_seen),
        .crc_fail_seen(crc_fail_seen), .power_ok_out(power_ok_out),
        .rail_en(rail_en), .cfg(cfg));

    host_model host (.clk(clk), .cmd(cmd), .rd_data(rd_data),
        .rd_valid(rd_valid), .cmd_refused(cmd_refused));

    // free-running 20 MHz clock
    always #25 clk = ~clk;

    // single value comparison, four-state exact
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // settle just after the nth edge
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic do_rd(input logic [7:0] code, input logic [7:0] exp,
        input logic ref_exp);
        host.xfer(1'b0, code, 8'h00, q, v, r);
        chk({24'h0, q}, {24'h0, exp});
        chk({31'h0, r}, {31'h0, ref_exp});
        if (!ref_exp) begin
            chk({31'h0, v}, 32'h1);
        end
    endtask

    task automatic do_wr(input logic [7:0] code, input logic [7:0] data,
        input logic ref_exp);
        host.xfer(1'b1, code, data, q, v, r);
        chk({31'h0, r}, {31'h0, ref_exp});
    endtask

    // values after reset
    task automatic t_reset();
        do_rd(`CMD_PAGE, 8'hFF, 1'b0);
        do_rd(`CMD_SPREAD, 8'h00, 1'b0);
        chk({12'h0, cfg}, 32'h0);
    endtask

    // every field reaches its output, reserved bits read zero
    task automatic t_fields();
        for (int i = 0; i < 17; i++) begin
            do_wr(t_code[i], t_data[i], 1'b0);
            do_rd(t_code[i], t_back[i], 1'b0);
            chk({12'h0, cfg}, {12'h0, t_cfg[i]});
            // fields above also cover driver, light-load, rate, input levels
            chk({12'h0, cfg}, {12'h0, t_cfg[i]});
            chk({12'h0, cfg}, {12'h0, t_cfg[i]});
            do_wr(t_code[i], 8'h00, 1'b0);
        end
    endtask

    // refused accesses leave state alone
    task automatic t_refuse();
        do_wr(`CMD_PAGE, 8'h05, 1'b1);
        do_rd(`CMD_PAGE, 8'hFF, 1'b0);
        do_wr(`CMD_PAGE, 8'h03, 1'b0);
        do_rd(`CMD_SPREAD, 8'h00, 1'b1);
        do_wr(`CMD_SPREAD, 8'h80, 1'b1);
        host.select_all(r);
        chk({31'h0, r}, 32'h0);
        chk({31'h0, cfg.spread_enable}, 32'h0);
        do_rd(8'hC6, 8'h00, 1'b1);
        do_wr(`CMD_VIN, 8'h0C, 1'b1);
        do_rd(`CMD_VIN, 8'h00, 1'b0);
    endtask

    // fault event with given mapping bit, flag and power ok checked
    task automatic t_fault(input logic map, input logic use_crc);
        do_wr(`CMD_FAULT_MAP, {4'h0, map, map, 2'b00}, 1'b0);
        wait_cyc(4);
        chk({31'h0, power_ok_out}, 32'h1);
        @(posedge clk);
        comm_fail <= !use_crc;
        crc_fail <= use_crc;
        @(posedge clk);
        comm_fail <= 1'b0;
        crc_fail <= 1'b0;
        wait_cyc(3);
        chk({30'h0, crc_fail_seen, comm_fail_seen}, {30'h0, use_crc, !use_crc});
        chk({31'h0, power_ok_out}, {31'h0, map});
        do_wr(`CMD_CLEAR, 8'h00, 1'b0);
        wait_cyc(4);
        chk({30'h0, crc_fail_seen, comm_fail_seen}, 32'h0);
        chk({31'h0, power_ok_out}, 32'h1);
    endtask

    // release delay of power ok after regulation is good
    task automatic t_power_ok_release_delay(input logic [1:0] sel, input int n);
        do_wr(`CMD_PG_CFG, {5'h0, sel, 1'b0}, 1'b0);
        @(posedge clk);
        power_ok_raw <= 1'b0;
        wait_cyc(3);
        chk({31'h0, power_ok_out}, 32'h0);
        @(posedge clk);
        power_ok_raw <= 1'b1;
        wait_cyc(n - 1);
        chk({31'h0, power_ok_out}, 32'h0);
        wait_cyc(6);
        chk({31'h0, power_ok_out}, 32'h1);
    endtask

    // turn-on and turn-off delays as count times unit
    task automatic t_seq(input logic unit, input logic [3:0] on_cnt,
        input logic [3:0] off_cnt, input int cyc);
        do_wr(`CMD_UNIT, {7'h0, unit}, 1'b0);
        do_wr(`CMD_SEQ, {on_cnt, off_cnt}, 1'b0);
        @(posedge clk);
        rail_on_req <= 1'b1;
        wait_cyc(int'(on_cnt) * cyc);
        chk({31'h0, rail_en}, 32'h0);
        wait_cyc(4);
        chk({31'h0, rail_en}, 32'h1);
        @(posedge clk);
        rail_on_req <= 1'b0;
        wait_cyc(int'(off_cnt) * cyc);
        chk({31'h0, rail_en}, 32'h1);
        wait_cyc(4);
        chk({31'h0, rail_en}, 32'h0);
    endtask

    // verdict and end of run
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        comm_fail = 1'b0;
        crc_fail = 1'b0;
        power_ok_raw = 1'b0;
        rail_on_req = 1'b0;
        bad_count = 0;
        samples_checked = 0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_fields();
        t_refuse();
        @(posedge clk);
        power_ok_raw <= 1'b1;
        t_fault(1'b0, 1'b0);
        t_fault(1'b1, 1'b0);
        t_fault(1'b0, 1'b1);
        t_fault(1'b1, 1'b1);
        t_power_ok_release_delay(2'b01, 8);
        t_power_ok_release_delay(2'b10, 16);
        t_power_ok_release_delay(2'b11, 24);
        t_seq(1'b0, 4'h2, 4'h1, US);
        t_seq(1'b1, 4'h1, 4'h0, UL);
        t_seq(1'b0, 4'hF, 4'hF, US);
        t_seq(1'b0, 4'h0, 4'h2, US);
        close_out();
    end

    // hang guard, far beyond the expected run
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        $display("watchdog expired");
        close_out();
    end
endmodule
